// ---- bench/fsp_host_model.sv ----
// host serial controller model
`timescale 1ns/1ps
`default_nettype none
module fsp_host_model (
   input wire fsp_pkg::fsp_drive_s drive_in,
   output logic shift_clock_out,
   output logic select_n_out,
   output logic [3:0] lane_out
);
   import fsp_pkg::*;
   // ====
   // link drive
   logic [3:0] hv = 4'hF;
   logic [3:0] ho = 4'hF;
   logic junk = 1'b0;
   logic cpol = 1'b0;
   initial shift_clock_out = 1'b0;
   initial select_n_out = 1'b0;
   always #32 junk = ~junk;
   always_comb for (int i = 0; i < 4; i++)
      lane_out[i] = drive_in.lane_oe[i] ? drive_in.lane_out[i]
         : (ho[i] ? hv[i] : junk);
   task automatic sel(input logic v);
      #40 select_n_out = v;
      #40;
   endtask : sel
   task automatic mode(input logic p);
      cpol = p;
      shift_clock_out = p;
   endtask : mode
   task automatic pin3(input logic v);
      hv[3] = v;
   endtask : pin3
   task automatic tick(input int n);
      repeat (n) begin
         #32 shift_clock_out = ~cpol;
         #32 shift_clock_out = cpol;
      end
   endtask : tick
   task automatic xfer(input int w, input logic [7:0] d, input logic rd,
         input logic rl, input logic pz, output logic [7:0] q);
      logic [3:0] ro;
      ro = w == 1 ? 4'hD : (w == 2 ? 4'hC : 4'h0);
      q = 8'h00;
      for (int k = 0; k < 8 / w; k++) begin
         shift_clock_out = 1'b0;
         ho = rd ? ro : (w == 1 ? 4'hD : 4'hF);
         if (w == 1)
            hv[0] = d[7 - k];
         else if (w == 2)
            hv[1:0] = d[7 - 2 * k -: 2];
         else
            hv = d[7 - 4 * k -: 4];
         #32 shift_clock_out = 1'b1;
         q = w == 4 ? {q[3:0], lane_out} : (w == 2 ? {q[5:0], lane_out[1:0]}
            : {q[6:0], lane_out[1]});
         if (pz && k == 3) begin
            hv[3] = 1'b0;
            repeat (8) begin
               #32 shift_clock_out = 1'b0;
               hv[0] = ~hv[0];
               #32 shift_clock_out = 1'b1;
            end
            hv[3] = 1'b1;
         end
         #32;
      end
      if (rl)
         ho = ro;
      shift_clock_out = cpol;
      hv[3:2] = 2'b11;
   endtask : xfer
endmodule : fsp_host_model
`default_nettype wire

// ---- bench/fsp_pin_front_props.sv ----
// checker on the pin front end ports
`timescale 1ns/1ps
`default_nettype none
module fsp_pin_front_props (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic shift_clock_in,
   input wire logic select_n_in,
   input wire logic [3:0] lane_in,
   input wire fsp_pkg::fsp_drive_s lane_drive_out,
   input wire fsp_pkg::fsp_cfg_s cfg_in,
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   input wire logic tx_ready_out,
   input wire logic [7:0] rx_data_out,
   input wire logic rx_valid_out,
   input wire logic selected_out,
   input wire logic standby_out,
   input wire logic device_reset_out
);
   import fsp_pkg::*;
   // ====
   // properties
   wire logic [3:0] oe = lane_drive_out.lane_oe;
   wire logic p3 = !cfg_in.quad_lane_enable && !lane_in[3];
   wire logic ps = p3 && !select_n_in && !cfg_in.pin3_function_select;
   wire logic rp = p3 && cfg_in.pin3_function_select;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_DESEL_FLOAT: assert property (select_n_in |-> oe == 4'h0)
      else $error("lanes driven while deselected");
   AST_ACTIVE: assert property (!select_n_in [*4] |-> !standby_out)
      else $error("standby while selected");
   AST_STANDBY: assert property (select_n_in [*4] |-> standby_out)
      else $error("no standby while deselected");
   AST_NO_RX: assert property (select_n_in [*8] |-> !rx_valid_out)
      else $error("byte taken while deselected");
   AST_RX_PULSE: assert property (rx_valid_out |=> !rx_valid_out)
      else $error("receive strobe longer than one cycle");
   AST_TX_TAKE: assert property (tx_valid_in && tx_ready_out
      |=> !tx_ready_out)
      else $error("offered byte not taken");
   AST_OE_ONE: assert property (cfg_in.width == FSP_SINGLE && oe != 4'h0
      |-> oe == 4'h2)
      else $error("single lane drive wrong");
   AST_OE_TWO: assert property (cfg_in.width == FSP_DUAL && oe != 4'h0
      |-> oe == 4'h3)
      else $error("dual lane drive wrong");
   AST_OE_FOUR: assert property (cfg_in.width == FSP_QUAD && oe != 4'h0
      |-> oe == 4'hF)
      else $error("quad lane drive wrong");
   AST_PAUSE: assert property (ps [*3] |-> oe == 4'h0)
      else $error("lanes driven while paused");
   AST_RST_PIN: assert property (rp [*5] |-> device_reset_out)
      else $error("reset pin ignored");
   AST_NO_RST: assert property (!rp [*4] |-> !device_reset_out)
      else $error("reset without reset pin");
endmodule : fsp_pin_front_props
bind fsp_pin_front fsp_pin_front_props chk_u (.clk_in(clk_in),
   .rst_n_in(rst_n_in), .shift_clock_in(shift_clock_in),
   .select_n_in(select_n_in), .lane_in(lane_in),
   .lane_drive_out(lane_drive_out), .cfg_in(cfg_in),
   .tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in),
   .tx_ready_out(tx_ready_out), .rx_data_out(rx_data_out),
   .rx_valid_out(rx_valid_out), .selected_out(selected_out),
   .standby_out(standby_out), .device_reset_out(device_reset_out));
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the pin front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import fsp_pkg::*;
   // ====
   // harness
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   fsp_cfg_s cfg = FSP_CFG_RESET;
   logic tv = 1'b0;
   logic [7:0] td = 8'h00;
   wire logic sck;
   wire logic sel_n;
   wire logic [3:0] lanes;
   wire fsp_drive_s drv;
   logic tx_rdy, rx_v, seld, stby, drst;
   logic [7:0] rx_d, q;
   logic [7:0] rxq[$];
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   fsp_pin_front dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .shift_clock_in(sck), .select_n_in(sel_n), .lane_in(lanes),
      .lane_drive_out(drv), .cfg_in(cfg), .tx_valid_in(tv),
      .tx_data_in(td), .tx_ready_out(tx_rdy), .rx_data_out(rx_d),
      .rx_valid_out(rx_v), .selected_out(seld), .standby_out(stby),
      .device_reset_out(drst));
   fsp_host_model host_u (.drive_in(drv), .shift_clock_out(sck),
      .select_n_out(sel_n), .lane_out(lanes));
   initial forever #50 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (rx_v === 1'b1)
         rxq.push_back(rx_d);
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wait_c(input int n);
      repeat (n) @(negedge clk_in);
   endtask : wait_c
   task automatic set_cfg(input fsp_width_e w, input logic e, input logic p);
      @(negedge clk_in) cfg = '{w, e, p};
      host_u.sel(1'b0);
      host_u.tick(2);
      host_u.sel(1'b1);
   endtask : set_cfg
   task automatic rx_frame(input int w, input logic [7:0] d0, d1,
         input logic pz);
      rxq.delete();
      host_u.sel(1'b0);
      wait_c(5);
      chk(seld, 1'b1);
      chk(stby, 1'b0);
      host_u.xfer(w, d0, 1'b0, 1'b0, pz, q);
      if (w < 4)
         host_u.xfer(w, d1, 1'b0, 1'b0, 1'b0, q);
      wait_c(6);
      host_u.sel(1'b1);
      wait_c(5);
      chk(stby, 1'b1);
      chk(8'(rxq.size()), w < 4 ? 8'h02 : 8'h01);
   endtask : rx_frame
   task automatic t_arm();
      rxq.delete();
      host_u.xfer(1, 8'hA5, 1'b0, 1'b0, 1'b0, q);
      wait_c(8);
      chk(8'(rxq.size()), 8'h00);
      host_u.sel(1'b1);
      $display("test arm done");
   endtask : t_arm
   task automatic t_single();
      rx_frame(1, 8'hA5, 8'h3C, 1'b0);
      chk(rxq[0], 8'hA5);
      chk(rxq[1], 8'h3C);
      $display("test single done");
   endtask : t_single
   task automatic t_desel();
      rxq.delete();
      host_u.xfer(1, 8'h99, 1'b0, 1'b0, 1'b0, q);
      wait_c(8);
      chk(8'(rxq.size()), 8'h00);
      $display("test deselect done");
   endtask : t_desel
   task automatic t_pause();
      rx_frame(1, 8'hE7, 8'h18, 1'b1);
      chk(rxq[0], 8'hE7);
      $display("test pause done");
   endtask : t_pause
   task automatic t_rst_pin();
      host_u.pin3(1'b0);
      wait_c(4);
      chk(drst, 1'b0);
      host_u.pin3(1'b1);
      set_cfg(FSP_SINGLE, 1'b0, 1'b1);
      host_u.pin3(1'b0);
      wait_c(4);
      chk(drst, 1'b1);
      host_u.pin3(1'b1);
      wait_c(4);
      chk(drst, 1'b0);
      set_cfg(FSP_SINGLE, 1'b0, 1'b0);
      $display("test reset pin done");
   endtask : t_rst_pin
   task automatic t_mode3();
      host_u.mode(1'b1);
      rx_frame(1, 8'hC6, 8'h81, 1'b0);
      chk(rxq[1], 8'h81);
      host_u.mode(1'b0);
      $display("test mode three done");
   endtask : t_mode3
   task automatic t_quad();
      set_cfg(FSP_QUAD, 1'b1, 1'b0);
      rx_frame(4, 8'h5A, 8'h00, 1'b0);
      chk(rxq[0], 8'h5A);
      $display("test quad done");
   endtask : t_quad
   task automatic t_tx(input int w, input logic [7:0] d);
      host_u.sel(1'b0);
      host_u.xfer(w, 8'h0B, 1'b0, 1'b1, 1'b0, q);
      @(negedge clk_in) tv = 1'b1;
      td = d;
      for (int i = 0; i < 20 && tx_rdy !== 1'b1; i++)
         @(negedge clk_in);
      @(negedge clk_in) tv = 1'b0;
      repeat (3) begin
         wait_c(2);
         host_u.tick(1);
      end
      host_u.xfer(w, 8'h00, 1'b1, 1'b0, 1'b0, q);
      chk(q, d);
      if (w < 4)
         host_u.xfer(w, 8'h00, 1'b1, 1'b0, 1'b0, q);
      host_u.sel(1'b1);
      wait_c(10);
      chk(tx_rdy, 1'b1);
      $display("test transmit done");
   endtask : t_tx
   initial begin
      host_u.tick(2);
      wait_c(4);
      rst_n_in = 1'b1;
      t_arm();
      t_single();
      t_desel();
      t_pause();
      t_rst_pin();
      t_mode3();
      t_tx(1, 8'hC3);
      set_cfg(FSP_DUAL, 1'b0, 1'b0);
      rx_frame(2, 8'h96, 8'h0F, 1'b0);
      chk(rxq[0], 8'h96);
      t_tx(2, 8'h69);
      t_quad();
      t_tx(4, 8'h1E);
      wrap_up();
   end
endmodule : testbench
`default_nettype wire

// ---- hdl/fsp_pin_front.sv ----
// serial flash pin front end: select, lanes, pause/reset pin, byte crossing
// What this block does
// RULE_01 - deselected: all output pins high impedance
// RULE_02 - select low: selected, active, transfers accepted
// RULE_03 - first instruction only after select falling edge
// RULE_04 - lanes ignored while select is high
// RULE_05 - deselected: standby, non-critical logic powered down
// RULE_06 - single lane: lane0 captured on rising clock
// RULE_07 - single lane: lane1 driven on falling clock
// RULE_08 - dual/quad: lanes bidirectional, rise in, fall out
// RULE_09 - quad: lanes two and three carry data
// RULE_10 - pin3 function selectable, pause after reset
// RULE_11 - select bit 0 pause, 1 reset
// RULE_12 - pause low while selected: float, freeze sequence
// RULE_13 - quad enable: pins two, three only data
// RULE_14 - only clock modes (0,0) and (1,1)
// RULE_15 - host releases shared lanes before device drives
`timescale 1ns/1ps
`default_nettype none

module fsp_pin_front (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic shift_clock_in,
   input wire logic select_n_in,
   input wire logic [3:0] lane_in,
   output fsp_pkg::fsp_drive_s lane_drive_out,
   input wire fsp_pkg::fsp_cfg_s cfg_in,
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   output logic tx_ready_out,
   output logic [7:0] rx_data_out,
   output logic rx_valid_out,
   output logic selected_out,
   output logic standby_out,
   output logic device_reset_out
);
   import fsp_pkg::*;

   // ======================================================================
   // link side: configuration and frame reset
   fsp_cfg_s cfg_meta;
   fsp_cfg_s cfg_link;
   logic pause_fn;
   logic reset_fn;
   logic pin_reset;
   logic paused;
   logic link_rst_n;

   always_ff @(posedge shift_clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_meta <= FSP_CFG_RESET; // RULE_10
         cfg_link <= FSP_CFG_RESET;
      end else begin
         cfg_meta <= cfg_in;
         cfg_link <= cfg_meta;
      end
   end

   // quad enable takes the pin functions away
   assign pause_fn = !cfg_link.quad_lane_enable &&
      cfg_link.pin3_function_select == FSP_PIN3_PAUSE; // RULE_11 RULE_13
   assign reset_fn = !cfg_link.quad_lane_enable &&
      cfg_link.pin3_function_select == FSP_PIN3_RESET; // RULE_11 RULE_13
   assign pin_reset = reset_fn && !lane_in[3];
   assign paused = pause_fn && !lane_in[3]; // RULE_12
   // select high or reset pin low clears the link shift registers, counters and lane drive
   assign link_rst_n = rst_n_in && !select_n_in && !pin_reset; // RULE_04 RULE_05

   // ======================================================================
   // link side: receive on rising edge
   logic [7:0] rx_sr;
   logic [3:0] rx_cnt;
   logic [3:0] rx_cnt_sum;
   logic [7:0] rx_hold;
   logic rx_tog;

   assign rx_cnt_sum = rx_cnt + fsp_step(cfg_link.width);

   // frozen while paused, never restarted by the pause
   always_ff @(posedge shift_clock_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_sr <= FSP_BYTE_ZERO;
         rx_cnt <= FSP_CNT_ZERO;
      end else if (!paused) begin // RULE_12
         rx_sr <= fsp_shift_in(rx_sr, lane_in, cfg_link.width); // RULE_06 RULE_08 RULE_09
         if (rx_cnt_sum == FSP_CNT_BYTE) begin
            rx_cnt <= FSP_CNT_ZERO;
         end else begin
            rx_cnt <= rx_cnt_sum;
         end
      end
   end

   // byte holding word and its event toggle survive select release
   always_ff @(posedge shift_clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_hold <= FSP_BYTE_ZERO;
         rx_tog <= 1'b0;
      end else if (link_rst_n && !paused && rx_cnt_sum == FSP_CNT_BYTE) begin // RULE_04
         rx_hold <= fsp_shift_in(rx_sr, lane_in, cfg_link.width);
         rx_tog <= !rx_tog;
      end
   end

   // ======================================================================
   // link side: transmit on falling edge
   logic tx_req;
   logic tx_req_meta;
   logic tx_req_link;
   logic tx_ack;
   logic [7:0] tx_sr;
   logic [3:0] tx_cnt;
   logic [3:0] tx_cnt_sum;
   logic tx_active;
   logic [7:0] tx_hold;

   assign tx_cnt_sum = tx_cnt + fsp_step(cfg_link.width);

   always_ff @(negedge shift_clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_req_meta <= 1'b0;
         tx_req_link <= 1'b0;
      end else begin
         tx_req_meta <= tx_req;
         tx_req_link <= tx_req_meta;
      end
   end

   // ack lives outside the frame reset so the handshake stays paired
   always_ff @(negedge shift_clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_ack <= 1'b0;
      end else if (link_rst_n && !paused && tx_cnt == FSP_CNT_ZERO &&
            tx_req_link != tx_ack) begin
         tx_ack <= tx_req_link;
      end
   end

   // a byte starts only on a boundary and only if one waits
   always_ff @(negedge shift_clock_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx_sr <= FSP_BYTE_ZERO;
         tx_cnt <= FSP_CNT_ZERO;
         tx_active <= 1'b0;
         lane_drive_out <= FSP_DRIVE_IDLE; // RULE_01
      end else if (paused) begin
         lane_drive_out.lane_oe <= FSP_OE_NONE; // RULE_12
      end else if (tx_cnt == FSP_CNT_ZERO) begin
         if (tx_req_link != tx_ack) begin
            tx_sr <= fsp_shift_out(tx_hold, cfg_link.width);
            tx_cnt <= tx_cnt_sum;
            tx_active <= 1'b1;
            lane_drive_out.lane_out <= fsp_lane_bits(tx_hold,
               cfg_link.width); // RULE_07 RULE_08 RULE_09
            lane_drive_out.lane_oe <= fsp_oe(cfg_link.width); // RULE_15
         end else begin
            tx_active <= 1'b0;
            lane_drive_out.lane_oe <= FSP_OE_NONE;
         end
      end else begin
         tx_sr <= fsp_shift_out(tx_sr, cfg_link.width);
         lane_drive_out.lane_out <= fsp_lane_bits(tx_sr, cfg_link.width); // RULE_07
         lane_drive_out.lane_oe <= fsp_oe(cfg_link.width); // RULE_08
         if (tx_cnt_sum == FSP_CNT_BYTE) begin
            tx_cnt <= FSP_CNT_ZERO;
         end else begin
            tx_cnt <= tx_cnt_sum;
         end
      end
   end

   // ======================================================================
   // system side: select, reset pin and receive event synchronisers
   logic sel_meta;
   logic sel_sync;
   logic sel_prev;
   logic rst_meta;
   logic rst_sync;
   logic rxt_meta;
   logic rxt_sync;
   logic rxt_prev;
   logic ack_meta;
   logic ack_sync;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel_meta <= 1'b0; // RULE_03
         sel_sync <= 1'b0;
         sel_prev <= 1'b0;
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
         rxt_meta <= 1'b0;
         rxt_sync <= 1'b0;
         rxt_prev <= 1'b0;
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
      end else begin
         sel_meta <= select_n_in;
         sel_sync <= sel_meta;
         sel_prev <= sel_sync;
         rst_meta <= pin_reset;
         rst_sync <= rst_meta;
         rxt_meta <= rx_tog;
         rxt_sync <= rxt_meta;
         rxt_prev <= rxt_sync;
         ack_meta <= tx_ack;
         ack_sync <= ack_meta;
      end
   end

   // ======================================================================
   // system side: power-up arming and frame state
   logic seen_high;
   logic frame_ok;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seen_high <= 1'b0;
         frame_ok <= 1'b0;
      end else begin
         if (sel_sync) begin
            seen_high <= 1'b1;
         end
         if (sel_sync) begin
            frame_ok <= 1'b0;
         end else if (sel_prev && seen_high) begin
            frame_ok <= 1'b1; // RULE_03
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         selected_out <= 1'b0;
         standby_out <= 1'b1;
         device_reset_out <= 1'b0;
      end else begin
         selected_out <= !sel_sync && frame_ok; // RULE_02
         standby_out <= sel_sync; // RULE_05
         device_reset_out <= rst_sync; // RULE_11
      end
   end

   // ======================================================================
   // system side: received bytes
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_data_out <= FSP_BYTE_ZERO;
         rx_valid_out <= 1'b0;
      end else begin
         rx_valid_out <= 1'b0;
         if (rxt_sync != rxt_prev && frame_ok) begin // RULE_03 RULE_04
            rx_data_out <= rx_hold;
            rx_valid_out <= 1'b1;
         end
      end
   end

   // ======================================================================
   // system side: transmit byte handshake
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_req <= 1'b0;
         tx_hold <= FSP_BYTE_ZERO;
         tx_ready_out <= 1'b1;
      end else if (tx_ready_out) begin
         if (tx_valid_in) begin
            tx_hold <= tx_data_in;
            tx_req <= !tx_req;
            tx_ready_out <= 1'b0;
         end
      end else if (ack_sync == tx_req) begin
         tx_ready_out <= 1'b1;
      end
   end

endmodule : fsp_pin_front

`default_nettype wire

// ---- hdl/fsp_pkg.sv ----
// shared types, constants and lane helpers for the flash serial pin front end
package fsp_pkg;

   // ======================================================================
   // types
   typedef enum logic [1:0] {FSP_SINGLE, FSP_DUAL, FSP_QUAD} fsp_width_e;

   typedef struct packed {
      fsp_width_e width;
      logic quad_lane_enable;
      logic pin3_function_select;
   } fsp_cfg_s;

   typedef struct packed {
      logic [3:0] lane_out;
      logic [3:0] lane_oe;
   } fsp_drive_s;

   // ======================================================================
   // constants
   localparam logic [3:0] FSP_CNT_ZERO = 4'h0;
   localparam logic [3:0] FSP_CNT_BYTE = 4'h8;
   localparam logic [3:0] FSP_STEP_SINGLE = 4'h1;
   localparam logic [3:0] FSP_STEP_DUAL = 4'h2;
   localparam logic [3:0] FSP_STEP_QUAD = 4'h4;
   localparam logic [3:0] FSP_OE_SINGLE = 4'h2;
   localparam logic [3:0] FSP_OE_DUAL = 4'h3;
   localparam logic [3:0] FSP_OE_QUAD = 4'hF;
   localparam logic [3:0] FSP_OE_NONE = 4'h0;
   localparam logic FSP_PIN3_PAUSE = 1'b0;
   localparam logic FSP_PIN3_RESET = 1'b1;
   localparam logic [7:0] FSP_BYTE_ZERO = 8'h00;
   localparam fsp_cfg_s FSP_CFG_RESET = {FSP_SINGLE, 1'b0, FSP_PIN3_PAUSE};
   localparam fsp_drive_s FSP_DRIVE_IDLE = {4'h0, FSP_OE_NONE};

   // ======================================================================
   // helpers
   function automatic logic [3:0] fsp_step(input fsp_width_e w);
      case (w)
         FSP_DUAL: fsp_step = FSP_STEP_DUAL;
         FSP_QUAD: fsp_step = FSP_STEP_QUAD;
         default: fsp_step = FSP_STEP_SINGLE;
      endcase
   endfunction : fsp_step

   function automatic logic [3:0] fsp_oe(input fsp_width_e w);
      case (w)
         FSP_DUAL: fsp_oe = FSP_OE_DUAL;
         FSP_QUAD: fsp_oe = FSP_OE_QUAD;
         default: fsp_oe = FSP_OE_SINGLE;
      endcase
   endfunction : fsp_oe

   function automatic logic [7:0] fsp_shift_in(input logic [7:0] sr,
         input logic [3:0] lanes, input fsp_width_e w);
      case (w)
         FSP_DUAL: fsp_shift_in = {sr[5:0], lanes[1], lanes[0]};
         FSP_QUAD: fsp_shift_in = {sr[3:0], lanes};
         default: fsp_shift_in = {sr[6:0], lanes[0]};
      endcase
   endfunction : fsp_shift_in

   function automatic logic [3:0] fsp_lane_bits(input logic [7:0] sr,
         input fsp_width_e w);
      case (w)
         FSP_DUAL: fsp_lane_bits = {2'b00, sr[7], sr[6]};
         FSP_QUAD: fsp_lane_bits = sr[7:4];
         default: fsp_lane_bits = {2'b00, sr[7], 1'b0};
      endcase
   endfunction : fsp_lane_bits

   function automatic logic [7:0] fsp_shift_out(input logic [7:0] sr,
         input fsp_width_e w);
      case (w)
         FSP_DUAL: fsp_shift_out = {sr[5:0], 2'b00};
         FSP_QUAD: fsp_shift_out = {sr[3:0], 4'h0};
         default: fsp_shift_out = {sr[6:0], 1'b0};
      endcase
   endfunction : fsp_shift_out

endpackage : fsp_pkg
